// file: design/ncs_pkg.sv
// Package: register map, field layout and reset values of the NVM control regs
package ncs_pkg;
    // =========================================================
    // Register offsets (byte addresses on the local bus)
    localparam logic [15:0] CLKDIV_OFS  = 16'h3020;
    localparam logic [15:0] PROT_OFS    = 16'h3021;
    localparam logic [15:0] INDEX_OFS   = 16'h3022;
    localparam logic [15:0] STATUS_OFS  = 16'h3026;
    localparam logic [15:0] CMDHI_OFS   = 16'h302A;
    localparam logic [15:0] CMDLO_OFS   = 16'h302B;
    // Global address of the nonvolatile protection byte
    localparam logic [15:0] PROT_NV_ADDR = 16'hFF7F;
    // =========================================================
    // Field positions
    localparam int WRITTEN_BIT = 7;
    localparam int LOCK_BIT    = 6;
    localparam int DIV_W       = 6;
    localparam int UNLK_EN_HI  = 7;
    localparam int UNLK_EN_LO  = 6;
    localparam int SEC_HI      = 1;
    localparam int SEC_LO      = 0;
    localparam int DONE_BIT    = 7;
    localparam int IDX_W       = 3;
    // Encodings
    localparam logic [1:0] UNLK_EN_ON  = 2'h2;
    localparam logic [1:0] SEC_UNSEC   = 2'h2;
    // =========================================================
    // Reset values
    localparam logic [7:0] CLKDIV_RST  = 8'h00;
    localparam logic [7:0] INDEX_RST   = 8'h00;
    localparam logic [7:0] PROT_RST    = 8'h00;
    // Timing of the divided tick
    localparam int TICK_TARGET_KHZ = 1000;
    localparam int CLK_MHZ         = 100;
    // Cycles one stand-in flash operation lasts, in derived ticks
    localparam int OP_TICKS        = 4;
endpackage : ncs_pkg

// file: design/ncs_tick_div.sv
// Divider that turns the bus clock into the ~1 MHz algorithm tick
`timescale 1ns/1ps
module ncs_tick_div #(
    parameter int W = 6
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] div,
    input  wire logic         run,
    output logic              tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } ncs_div_t;

    ncs_div_t s_r;
    ncs_div_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = '0;
        // Count 0..div, so div+1 bus cycles per tick
        end else if (s_r.cnt >= div) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

    property p_tick_gap;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && s_r.tick && run && div != '0) |=> !s_r.tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("tick on two cycles in a row");
endmodule : ncs_tick_div

// file: design/ncs_nv_loader.sv
// Reset-time fetch of the nonvolatile protection byte
`timescale 1ns/1ps
module ncs_nv_loader (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    output logic             nv_rd,
    output logic [15:0]      nv_addr,
    input  wire logic [7:0]  nv_data,
    output logic             load,
    output logic [7:0]       byte_out,
    output logic             ready
);
    typedef enum logic [1:0] {LD_REQ, LD_WAIT, LD_DONE} ncs_ld_st_t;
    typedef struct packed {
        ncs_ld_st_t st;
        logic       load;
        logic [7:0] data;
    } ncs_ld_t;

    ncs_ld_t s_r;
    ncs_ld_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.load = 1'b0;
        case (s_r.st)
            LD_REQ:  s_nxt.st = LD_WAIT;
            LD_WAIT: begin
                // Memory answers one cycle after the read strobe
                s_nxt.st   = LD_DONE;
                s_nxt.data = nv_data;
                s_nxt.load = 1'b1;
            end
            LD_DONE: s_nxt.st = LD_DONE;
            default: s_nxt.st = LD_REQ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '{st: LD_REQ, load: 1'b0, data: 8'h00};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign nv_rd    = (s_r.st == LD_REQ);
    assign nv_addr  = ncs_pkg::PROT_NV_ADDR;
    assign load     = s_r.load;
    assign byte_out = s_r.data;
    assign ready    = (s_r.st == LD_DONE);
endmodule : ncs_nv_loader

// file: design/ncs_regs.sv
// NVM clock divider, protection and command index registers
//
// Behaviour
// - Bit 7 of the divider register reads 1 once it is written while idle after reset.
// - With the lock bit 6 set the divider ignores writes until reset.
// - The six-bit divider derives a ~1 MHz tick that times operations.
// - The protection register reads fully and ignores software writes.
// - The protection register is loaded from the byte at 0xFF7F at reset.
// - Backdoor unlock is enabled only by the field value 10 in bits 7-6.
// - The security field means unsecured only for the encoding 10.
// - A backdoor unlock forces the security field to 10.
// - Bits 7-3 of the command index register always read 0.
// - The index low bits pick the command word reads and writes reach.
// - The done flag sets when a launched operation finishes.
`timescale 1ns/1ps
module ncs_regs #(
    parameter int WORDS = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [7:0]       rdata,
    input  wire logic        backdoor_unlock,
    output logic             nv_rd,
    output logic [15:0]      nv_addr,
    input  wire logic [7:0]  nv_data,
    output logic             unsecured,
    output logic             backdoor_enabled,
    output logic             divider_written_flag,
    output logic             command_done_flag,
    output logic             algo_tick
);
    localparam int IW = ncs_pkg::IDX_W;
    localparam int DW = ncs_pkg::DIV_W;

    typedef enum logic [1:0] {OP_IDLE, OP_RUN} ncs_op_st_t;

    typedef struct packed {
        logic [DW-1:0]  divider_value;
        logic           divider_written_flag;
        logic           divider_lock_flag;
        logic [7:0]     prot;
        logic [IW-1:0]  command_word_index;
        logic           command_done_flag;
        ncs_op_st_t     op;
        logic [3:0]     ticks;
        logic [7:0]     rdata;
        logic           unsecured;
        logic           bd_en;
        logic           tick_o;
        logic           nv_rd;
        logic [15:0]    nv_addr;
    } ncs_regs_t;

    ncs_regs_t s_r;
    ncs_regs_t s_nxt;

    // =========================================================
    // Command object words, high and low bytes
    logic [7:0] cmd_hi [WORDS];
    logic [7:0] cmd_lo [WORDS];

    // =========================================================
    // Submodules
    logic       tick;
    logic       ld_rd;
    logic [15:0] ld_addr;
    logic       ld_load;
    logic [7:0] ld_byte;
    logic       ld_ready;

    ncs_tick_div #(
        .W (DW)
    ) u_div (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .div     (s_r.divider_value),
        .run     (s_r.op == OP_RUN),
        .tick    (tick)
    );

    ncs_nv_loader u_ld (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .nv_rd    (ld_rd),
        .nv_addr  (ld_addr),
        .nv_data  (nv_data),
        .load     (ld_load),
        .byte_out (ld_byte),
        .ready    (ld_ready)
    );

    // Backdoor request comes from outside the clock domain
    logic [1:0] bd_sync_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bd_sync_r <= 2'h0;
        end else if (ce) begin
            bd_sync_r <= {bd_sync_r[0], backdoor_unlock};
        end
    end

    // =========================================================
    // Decode
    logic wr_div;
    logic wr_idx;
    logic wr_stat;
    logic wr_hi;
    logic wr_lo;
    logic bd_key_on;

    assign wr_div  = wr && addr == ncs_pkg::CLKDIV_OFS;
    assign wr_idx  = wr && addr == ncs_pkg::INDEX_OFS;
    assign wr_stat = wr && addr == ncs_pkg::STATUS_OFS;
    assign wr_hi   = wr && addr == ncs_pkg::CMDHI_OFS;
    assign wr_lo   = wr && addr == ncs_pkg::CMDLO_OFS;
    assign bd_key_on =
        s_r.prot[ncs_pkg::UNLK_EN_HI:ncs_pkg::UNLK_EN_LO]
        == ncs_pkg::UNLK_EN_ON;

    always_comb begin
        s_nxt         = s_r;
        s_nxt.rdata   = 8'h00;
        s_nxt.tick_o  = tick;
        s_nxt.nv_rd   = ld_rd;
        s_nxt.nv_addr = ld_addr;

        // Divider writes only while idle and unlocked
        if (wr_div && s_r.command_done_flag) begin
            s_nxt.divider_written_flag = 1'b1;
            if (!s_r.divider_lock_flag) begin
                s_nxt.divider_value     = wdata[DW-1:0];
                s_nxt.divider_lock_flag = wdata[ncs_pkg::LOCK_BIT];
            end
        end

        if (wr_idx) begin
            s_nxt.command_word_index = wdata[IW-1:0];
        end

        // Protection byte: reset-time load only, bus writes dropped
        if (ld_load) begin
            s_nxt.prot = ld_byte;
        end
        // Backdoor only counts once the byte is loaded
        if (ld_ready && bd_sync_r[1] && bd_key_on) begin
            s_nxt.prot[ncs_pkg::SEC_HI:ncs_pkg::SEC_LO] =
                ncs_pkg::SEC_UNSEC;
        end
        s_nxt.bd_en     = bd_key_on;
        s_nxt.unsecured = s_r.prot[ncs_pkg::SEC_HI:ncs_pkg::SEC_LO]
                          == ncs_pkg::SEC_UNSEC;

        // Minimal operation timer standing in for the sequencer
        case (s_r.op)
            OP_IDLE: begin
                // Writing 1 to the done flag clears it and launches
                if (wr_stat && wdata[ncs_pkg::DONE_BIT]
                    && s_r.command_done_flag) begin
                    s_nxt.command_done_flag = 1'b0;
                    s_nxt.op                = OP_RUN;
                    s_nxt.ticks             = 4'h0;
                end
            end
            OP_RUN: begin
                if (tick) begin
                    s_nxt.ticks = s_r.ticks + 4'h1;
                    if (s_r.ticks == 4'(ncs_pkg::OP_TICKS - 1)) begin
                        s_nxt.command_done_flag = 1'b1;
                        s_nxt.op                = OP_IDLE;
                    end
                end
            end
            default: s_nxt.op = OP_IDLE;
        endcase

        if (rd) begin
            case (addr)
                ncs_pkg::CLKDIV_OFS: s_nxt.rdata =
                    {s_r.divider_written_flag, s_r.divider_lock_flag,
                     s_r.divider_value};
                ncs_pkg::PROT_OFS:   s_nxt.rdata = s_r.prot;
                ncs_pkg::INDEX_OFS:  s_nxt.rdata =
                    {5'h00, s_r.command_word_index};
                ncs_pkg::STATUS_OFS: s_nxt.rdata =
                    {s_r.command_done_flag, 7'h00};
                ncs_pkg::CMDHI_OFS:  s_nxt.rdata =
                    cmd_hi[s_r.command_word_index];
                ncs_pkg::CMDLO_OFS:  s_nxt.rdata =
                    cmd_lo[s_r.command_word_index];
                default:             s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '{divider_value: ncs_pkg::CLKDIV_RST[DW-1:0],
                     divider_written_flag: 1'b0,
                     divider_lock_flag: 1'b0,
                     prot: ncs_pkg::PROT_RST,
                     command_word_index: ncs_pkg::INDEX_RST[IW-1:0],
                     command_done_flag: 1'b1,
                     op: OP_IDLE,
                     ticks: 4'h0,
                     rdata: 8'h00,
                     unsecured: 1'b0,
                     bd_en: 1'b0,
                     tick_o: 1'b0,
                     nv_rd: 1'b0,
                     nv_addr: 16'h0000};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Array has no reset; software loads words before launch
    always_ff @(posedge ref_clk) begin
        if (ce && s_r.command_done_flag) begin
            if (wr_hi) begin
                cmd_hi[s_r.command_word_index] <= wdata;
            end
            if (wr_lo) begin
                cmd_lo[s_r.command_word_index] <= wdata;
            end
        end
    end

    assign rdata                = s_r.rdata;
    assign unsecured            = s_r.unsecured;
    assign backdoor_enabled     = s_r.bd_en;
    assign divider_written_flag = s_r.divider_written_flag;
    assign command_done_flag    = s_r.command_done_flag;
    assign algo_tick            = s_r.tick_o;
    assign nv_rd                = s_r.nv_rd;
    assign nv_addr              = s_r.nv_addr;

    // =========================================================
    // Checks
    property p_lock_holds;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && s_r.divider_lock_flag) |=>
            (s_r.divider_lock_flag && $stable(s_r.divider_value));
    endproperty
    a_lock_holds: assert property (p_lock_holds)
        else $error("locked divider changed");

    property p_written_set;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && wr_div && s_r.command_done_flag) |=> s_r.divider_written_flag;
    endproperty
    a_written_set: assert property (p_written_set)
        else $error("written flag not set");

    property p_written_sticky;
        @(posedge ref_clk) disable iff (!rst_n)
        s_r.divider_written_flag |=> s_r.divider_written_flag;
    endproperty
    a_written_sticky: assert property (p_written_sticky)
        else $error("written flag dropped");

    property p_busy_ignore;
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_div && !s_r.command_done_flag) |=>
            ($stable(s_r.divider_value) && $stable(s_r.divider_lock_flag));
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("divider changed while busy");

    property p_prot_ro;
        @(posedge ref_clk) disable iff (!rst_n)
        // Load cycle itself is the one legal change besides the backdoor
        (ld_ready && !ld_load && !bd_sync_r[1]) |=> $stable(s_r.prot);
    endproperty
    a_prot_ro: assert property (p_prot_ro)
        else $error("protection register changed");

    property p_prot_load;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ld_load && !bd_sync_r[1]) |=> s_r.prot == $past(ld_byte);
    endproperty
    a_prot_load: assert property (p_prot_load)
        else $error("protection byte not loaded");

    property p_index_read;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && rd && addr == ncs_pkg::INDEX_OFS) |=> rdata[7:3] == 5'h00;
    endproperty
    a_index_read: assert property (p_index_read)
        else $error("index upper bits not zero");

    property p_backdoor_unlock_enable;
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> backdoor_enabled == ($past(s_r.prot[7:6]) == 2'h2);
    endproperty
    a_backdoor_unlock_enable: assert property (p_backdoor_unlock_enable)
        else $error("backdoor enable decode wrong");

    property p_unsec;
        @(posedge ref_clk) disable iff (!rst_n)
        ce |=> unsecured == ($past(s_r.prot[1:0]) == 2'h2);
    endproperty
    a_unsec: assert property (p_unsec)
        else $error("security decode wrong");

    property p_force;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && ld_ready && bd_sync_r[1] && bd_key_on && !ld_load)
            |=> s_r.prot[1:0] == 2'h2;
    endproperty
    a_force: assert property (p_force)
        else $error("backdoor did not unsecure");

    property p_done_after_run;
        @(posedge ref_clk) disable iff (!rst_n)
        (ce && s_r.op == OP_RUN && tick && s_r.ticks == 4'h3)
            |=> command_done_flag;
    endproperty
    a_done_after_run: assert property (p_done_after_run)
        else $error("done flag not set at end");
endmodule : ncs_regs

// file: bench/tb_top.sv
// Self-checking bench for the NVM divider, protection and index registers
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // Signals
    logic        ref_clk              = 1'b0;
    logic        rst_n                = 1'b0;
    logic        ce                   = 1'b1;
    logic [15:0] addr                 = 16'h0000;
    logic [7:0]  wdata                = 8'h00;
    logic        wr                   = 1'b0;
    logic        rd                   = 1'b0;
    logic [7:0]  rdata;
    logic        backdoor_unlock      = 1'b0;
    logic        nv_rd;
    logic [15:0] nv_addr;
    logic [7:0]  nv_data              = 8'h00;
    logic        unsecured;
    logic        backdoor_enabled;
    logic        divider_written_flag;
    logic        command_done_flag;
    logic        algo_tick;
    int          n_errors             = 0;
    int          compares             = 0;
    int          cyc                  = 0;
    logic [7:0]  v;
    logic [7:0]  r;
    int          gap;

    ncs_regs #(.WORDS(8)) DUT (
        .ref_clk              (ref_clk),
        .rst_n                (rst_n),
        .ce                   (ce),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .backdoor_unlock      (backdoor_unlock),
        .nv_rd                (nv_rd),
        .nv_addr              (nv_addr),
        .nv_data              (nv_data),
        .unsecured            (unsecured),
        .backdoor_enabled     (backdoor_enabled),
        .divider_written_flag (divider_written_flag),
        .command_done_flag    (command_done_flag),
        .algo_tick            (algo_tick)
    );

    always #5 ref_clk = ~ref_clk;

    // ==========================================================
    // Tasks
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Flag picked by number, so no reference argument is needed
    function automatic logic flag_of(input int sel);
        case (sel)
            0:       return nv_rd;
            1:       return unsecured;
            2:       return algo_tick;
            default: return command_done_flag;
        endcase
    endfunction : flag_of

    // Bounded wait for a flag, sampled just after each edge
    task automatic wait_high(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge ref_clk);
            #1;
            if (flag_of(sel) === 1'b1)
                break;
        end
    endtask : wait_high

    task automatic do_reset(input logic [7:0] nv);
        @(posedge ref_clk);
        rst_n   <= 1'b0;
        nv_data <= nv;
        repeat (8) @(posedge ref_clk);
        rst_n   <= 1'b1;
        wait_high(0, 10);
        check({7'h00, nv_rd}, 8'h01);
        check(nv_addr[15:8], ncs_pkg::PROT_NV_ADDR[15:8]);
        check(nv_addr[7:0], ncs_pkg::PROT_NV_ADDR[7:0]);
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    // ==========================================================
    // Hang guard: whole run is well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ==========================================================
    // Tests
    initial begin
        for (int k = 0; k < 4; k++) begin
            v = {k[1:0], 4'h5, k[1:0]};
            do_reset(v);
            rd_reg(ncs_pkg::PROT_OFS, r);
            check(r, v);
            wr_reg(ncs_pkg::PROT_OFS, ~v);
            rd_reg(ncs_pkg::PROT_OFS, r);
            check(r, v);
            check({7'h00, backdoor_enabled}, {7'h00, k == 2});
            check({7'h00, unsecured}, {7'h00, k == 2});
        end
        $display("test protection encodings done");

        do_reset(8'h94);
        check({7'h00, unsecured}, 8'h00);
        @(posedge ref_clk);
        backdoor_unlock <= 1'b1;
        wait_high(1, 10);
        check({7'h00, unsecured}, 8'h01);
        rd_reg(ncs_pkg::PROT_OFS, r);
        check(r, 8'h96);
        @(posedge ref_clk);
        backdoor_unlock <= 1'b0;
        $display("test backdoor unlock done");

        do_reset(8'h00);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'h00);
        check({7'h00, divider_written_flag}, 8'h00);
        wr_reg(ncs_pkg::CLKDIV_OFS, 8'h03);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'h83);
        check({7'h00, divider_written_flag}, 8'h01);
        wr_reg(ncs_pkg::CLKDIV_OFS, 8'h45);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'hC5);
        wr_reg(ncs_pkg::CLKDIV_OFS, 8'h07);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'hC5);
        do_reset(8'h00);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'h00);
        wr_reg(ncs_pkg::CLKDIV_OFS, 8'h05);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'h85);
        $display("test divider and lock done");

        // Write while busy on purpose: must leave the divider alone
        wr_reg(ncs_pkg::STATUS_OFS, 8'h80);
        check({7'h00, command_done_flag}, 8'h00);
        wr_reg(ncs_pkg::CLKDIV_OFS, 8'h41);
        wait_high(2, 20);
        gap = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1;
            gap++;
            if (algo_tick === 1'b1)
                break;
        end
        check(8'(gap), 8'h06);
        wait_high(3, 100);
        check({7'h00, command_done_flag}, 8'h01);
        rd_reg(ncs_pkg::CLKDIV_OFS, r);
        check(r, 8'h85);
        $display("test busy operation done");

        wr_reg(ncs_pkg::INDEX_OFS, 8'hFF);
        rd_reg(ncs_pkg::INDEX_OFS, r);
        check(r, 8'h07);
        for (int i = 0; i < 8; i++) begin
            wr_reg(ncs_pkg::INDEX_OFS, 8'(i));
            wr_reg(ncs_pkg::CMDHI_OFS, 8'(8'hA0 + i));
            wr_reg(ncs_pkg::CMDLO_OFS, 8'(8'h50 + i));
        end
        for (int i = 0; i < 8; i++) begin
            wr_reg(ncs_pkg::INDEX_OFS, 8'(i));
            rd_reg(ncs_pkg::CMDHI_OFS, r);
            check(r, 8'(8'hA0 + i));
            rd_reg(ncs_pkg::CMDLO_OFS, r);
            check(r, 8'(8'h50 + i));
        end
        // Clock enable low: the write must be lost
        @(posedge ref_clk);
        ce <= 1'b0;
        wr_reg(ncs_pkg::INDEX_OFS, 8'h02);
        @(posedge ref_clk);
        ce <= 1'b1;
        rd_reg(ncs_pkg::INDEX_OFS, r);
        check(r, 8'h07);
        rd_reg(16'h3023, r);
        check(r, 8'h00);
        $display("test command index done");
        end_of_test();
    end
endmodule : tb_top
